// ### hw/crc_run_control.sv
// Run control register of a small real-time core on an Avalon-MM slave
`timescale 1ns/10ps
`include "crc_regs.svh"
module crc_run_control (
    input  wire logic                    core_clk,
    input  wire logic                    sys_rst,
    // Avalon-MM slave
    input  wire logic [`CRC_ADDR_W-1:0]  avs_address,
    input  wire logic                    avs_read,
    input  wire logic                    avs_write,
    input  wire logic [31:0]             avs_writedata,
    input  wire logic [3:0]              avs_byteenable,
    output logic      [31:0]             avs_readdata,
    output logic                         avs_waitrequest,
    // Core side, same clock
    input  wire logic                    coreInstrDone,
    input  wire logic                    coreMultiBusy,
    input  wire logic                    coreSleeping,
    output logic                         coreFetchEnable,
    output logic                         coreStepMode,
    output logic                         coreSoftReset,
    output logic      [15:0]             coreStartAddress,
    output logic                         cycleCountEnable,
    output logic                         coreWakeForce,
    output logic                         hostLockout,
    output logic                         executionIndicator
);

    crc_pkg::crc_ctl_state_t stateFf;   // Registered state
    crc_pkg::crc_ctl_state_t nxtState;  // Next state

    logic        busReq;    // A request is pending
    logic        ctlHit;    // Address selects the register
    logic        wrHit;     // Write takes effect now
    logic [31:0] ctlWord;   // Register as read
    logic [31:0] wrWord;    // Write merged by byte lanes

    crc_core_if coreIf ();  // Link to the tracker

    // Merge write data into a word by byte enables
    function automatic logic [31:0] byteMerge(
        input logic [31:0] oldWord,
        input logic [31:0] newWord,
        input logic [3:0]  lanes
    );
        logic [31:0] res;
        // Lanes left out keep the old byte
        res = oldWord;
        for (int i = 0; i < 4; i++) begin
            if (lanes[i]) begin
                res[i*8 +: 8] = newWord[i*8 +: 8];
            end
        end
        return res;
    endfunction : byteMerge

    // Bus decode
    assign busReq  = avs_read || avs_write;
    assign ctlHit  = (avs_address == `CRC_CTRL_OFS); // see RL1
    // Writes land only in the answered cycle, so each request lands once
    assign wrHit   = avs_write && stateFf.ack && ctlHit;

    // Register image; bit 14 always reads zero
    always_comb begin
        // Bit 15 comes from the tracker, bit 2 straight from the core
        ctlWord = '0;
        ctlWord[`CRC_START_HI:`CRC_START_LO] = stateFf.startAddr; // see RL2
        ctlWord[`CRC_B_RUN]   = coreIf.running; // see RL3
        ctlWord[`CRC_B_RSV14] = 1'b0; // see RL15
        ctlWord[`CRC_RSVA_HI:`CRC_RSVA_LO] = stateFf.rsvA;
        ctlWord[`CRC_B_STEP]  = stateFf.step;
        ctlWord[`CRC_RSVB_HI:`CRC_RSVB_LO] = stateFf.rsvB;
        ctlWord[`CRC_B_CNT]   = stateFf.cntEn;
        ctlWord[`CRC_B_SLEEP] = coreSleeping; // see RL10
        ctlWord[`CRC_B_EN]    = stateFf.enable;
        ctlWord[`CRC_B_RSTN]  = stateFf.rstN;
    end

    // Read-only bits merged here are never stored back
    assign wrWord = byteMerge(ctlWord, avs_writedata, avs_byteenable);

    // Next-state logic
    always_comb begin
        nxtState = stateFf;
        // Strobes last one cycle
        nxtState.softRst = 1'b0;
        nxtState.wake    = 1'b0;
        // Soft reset bit returns to one next cycle
        nxtState.rstN    = 1'b1; // see RL14
        // Answer one cycle after the request arrives
        nxtState.ack     = busReq && !stateFf.ack;
        // Capture read data in the first cycle
        if (avs_read && !stateFf.ack) begin
            nxtState.readData = ctlHit ? ctlWord : 32'h0000_0000;
        end
        // Single step: clear enable after one instruction
        if (stateFf.enable && stateFf.step && coreInstrDone) begin
            nxtState.enable = 1'b0; // see RL6
        end
        // Host write; a set of enable wins over the step clear
        if (wrHit) begin
            nxtState.startAddr = wrWord[`CRC_START_HI:`CRC_START_LO]; // see RL2
            nxtState.rsvA      = wrWord[`CRC_RSVA_HI:`CRC_RSVA_LO]; // see RL15
            nxtState.rsvB      = wrWord[`CRC_RSVB_HI:`CRC_RSVB_LO]; // see RL15
            nxtState.step      = wrWord[`CRC_B_STEP]; // see RL8
            nxtState.enable    = wrWord[`CRC_B_EN]; // see RL8
            nxtState.cntEn     = wrWord[`CRC_B_CNT]; // see RL9
            // Zero to the sleep bit forces wake-up
            if (avs_byteenable[0] && !wrWord[`CRC_B_SLEEP]) begin
                nxtState.wake = 1'b1; // see RL11
            end
            // Zero to the reset bit resets the core
            if (avs_byteenable[0] && !wrWord[`CRC_B_RSTN]) begin
                nxtState.rstN    = 1'b0; // see RL14
                nxtState.softRst = 1'b1; // see RL14
            end
        end
    end

    // State register
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            // Everything clears except the soft reset bit
            stateFf          <= '0;
            stateFf.rstN     <= 1'b1; // see RL1
        end else begin
            stateFf          <= nxtState;
        end
    end

    // Tracker of the run state
    // It stands in for the core's own halt logic
    crc_run_tracker uTracker (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .coreIf   (coreIf)
    );

    // Tracker inputs
    assign coreIf.fetchEn   = stateFf.enable; // see RL7
    assign coreIf.instrDone = coreInstrDone;
    assign coreIf.multiBusy = coreMultiBusy;

    // Bus outputs
    // Wait state only in the first cycle of a request
    assign avs_waitrequest  = busReq && !stateFf.ack;
    assign avs_readdata     = stateFf.readData;

    // Core outputs
    // Pulses and levels come straight from flops; hostLockout and executionIndicator decode the tracker state
    assign coreFetchEnable    = stateFf.enable; // see RL5
    assign coreStepMode       = stateFf.step;
    assign coreSoftReset      = stateFf.softRst;
    assign coreStartAddress   = stateFf.startAddr;
    assign cycleCountEnable   = stateFf.cntEn; // see RL9
    assign coreWakeForce      = stateFf.wake;
    assign hostLockout        = coreIf.running; // see RL4
    assign executionIndicator = coreIf.running;

    // Checks
    // All checks share the bus clock and the reset
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    // Value after reset
    property p_rst_value;
        $past(sys_rst) && !coreIf.running && !coreSleeping |-> ctlWord == `CRC_CTRL_RST;
    endproperty
    a_rst_value: assert property (p_rst_value) else $error("bad reset value"); // see RL1

    // Start address follows the write
    property p_start_addr;
        wrHit && (avs_byteenable[3:2] == 2'b11) |=> coreStartAddress == $past(avs_writedata[`CRC_START_HI:`CRC_START_LO]);
    endproperty
    a_start_addr: assert property (p_start_addr) else $error("start address not stored"); // see RL2

    // Halted core with fetch off stays halted and grants access
    property p_halt_access;
        !$past(coreFetchEnable) && !$past(executionIndicator) |-> !hostLockout && !ctlWord[`CRC_B_RUN];
    endproperty
    a_halt_access: assert property (p_halt_access) else $error("halted core still locked"); // see RL3

    // Fetch enabled a cycle ago: core runs and locks the host out
    property p_run_lock;
        $past(coreFetchEnable) |-> hostLockout && ctlWord[`CRC_B_RUN];
    endproperty
    a_run_lock: assert property (p_run_lock) else $error("running core not locked"); // see RL4

    // Free run keeps fetch enabled
    property p_free_run;
        stateFf.enable && !stateFf.step && !wrHit |=> coreFetchEnable;
    endproperty
    a_free_run: assert property (p_free_run) else $error("free run stopped"); // see RL5

    // Step clears enable after one instruction
    property p_step_stop;
        stateFf.enable && stateFf.step && coreInstrDone && !wrHit |=> !coreFetchEnable;
    endproperty
    a_step_stop: assert property (p_step_stop) else $error("step did not stop"); // see RL6

    // Step alone does not start
    property p_step_alone;
        wrHit && avs_byteenable[1] && avs_byteenable[0] && avs_writedata[`CRC_B_STEP] &&
        !avs_writedata[`CRC_B_EN] |=> !coreFetchEnable [*2];
    endproperty
    a_step_alone: assert property (p_step_alone) else $error("step alone started core"); // see RL7

    // Both bits in one write
    property p_step_both;
        wrHit && avs_byteenable[1] && avs_byteenable[0] && avs_writedata[`CRC_B_STEP] &&
        avs_writedata[`CRC_B_EN] |=> coreFetchEnable && coreStepMode;
    endproperty
    a_step_both: assert property (p_step_both) else $error("joint write failed"); // see RL8

    // Counter enable follows the write
    property p_cnt_en;
        wrHit && avs_byteenable[0] |=> cycleCountEnable == $past(avs_writedata[`CRC_B_CNT]);
    endproperty
    a_cnt_en: assert property (p_cnt_en) else $error("counter enable wrong"); // see RL9

    // Sleep bit shows the core
    property p_sleep_bit;
        ctlWord[`CRC_B_SLEEP] == coreSleeping;
    endproperty
    a_sleep_bit: assert property (p_sleep_bit) else $error("sleep bit wrong"); // see RL10

    // Writing zero wakes for one cycle
    property p_wake;
        wrHit && avs_byteenable[0] && !avs_writedata[`CRC_B_SLEEP] |=> coreWakeForce ##1 !coreWakeForce;
    endproperty
    a_wake: assert property (p_wake) else $error("wake pulse wrong"); // see RL11

    // Halted core keeps its enable state until told
    property p_enable_hold;
        !stateFf.enable && !wrHit |=> !coreFetchEnable;
    endproperty
    a_enable_hold: assert property (p_enable_hold) else $error("enable set by itself"); // see RL12

    // Soft reset pulse and bit return
    property p_soft_rst;
        wrHit && avs_byteenable[0] && !avs_writedata[`CRC_B_RSTN]
        |=> coreSoftReset && !ctlWord[`CRC_B_RSTN] ##1 !coreSoftReset && ctlWord[`CRC_B_RSTN];
    endproperty
    a_soft_rst: assert property (p_soft_rst) else $error("soft reset sequence wrong"); // see RL14

    // Reserved bits
    property p_reserved;
        wrHit && avs_byteenable[1] |=> !ctlWord[`CRC_B_RSV14] &&
        ctlWord[`CRC_RSVA_HI:`CRC_RSVA_LO] == $past(avs_writedata[`CRC_RSVA_HI:`CRC_RSVA_LO]);
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits wrong"); // see RL15

    // Read data are the image of the first request cycle
    property p_read_value;
        avs_read && ctlHit && !avs_waitrequest |-> avs_readdata == $past(ctlWord);
    endproperty
    a_read_value: assert property (p_read_value) else $error("read data wrong"); // see RL1

    // Unmapped reads return zero
    property p_unmapped_read;
        avs_read && !ctlHit && !avs_waitrequest |-> avs_readdata == 32'h0000_0000;
    endproperty
    a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero"); // see RL1

    // Unmapped writes leave the register alone
    property p_unmapped_write;
        avs_write && !ctlHit && !avs_waitrequest |=> $stable(coreStartAddress) && $stable(cycleCountEnable) &&
        $stable(coreStepMode);
    endproperty
    a_unmapped_write: assert property (p_unmapped_write) else $error("unmapped write stored"); // see RL1

    // One wait state per request
    property p_wait_once;
        busReq && avs_waitrequest |=> !avs_waitrequest;
    endproperty
    a_wait_once: assert property (p_wait_once) else $error("wait state too long"); // see RL1

    // Start address resets to zero
    property p_start_reset;
        $past(sys_rst) |-> coreStartAddress == '0;
    endproperty
    a_start_reset: assert property (p_start_reset) else $error("start address not reset"); // see RL2

    // Start address changes only by a write
    property p_start_hold;
        !wrHit |=> $stable(coreStartAddress);
    endproperty
    a_start_hold: assert property (p_start_hold) else $error("start address changed by itself"); // see RL2

    // Step policy changes only by a write
    property p_step_hold;
        !wrHit |=> $stable(coreStepMode);
    endproperty
    a_step_hold: assert property (p_step_hold) else $error("step policy changed by itself"); // see RL5

    // Counter gate resets to zero
    property p_cnt_reset;
        $past(sys_rst) |-> !cycleCountEnable;
    endproperty
    a_cnt_reset: assert property (p_cnt_reset) else $error("counter gate not reset"); // see RL9

    // Soft reset bit reads one unless cleared a cycle ago
    property p_rst_bit_one;
        !$past(wrHit) |-> ctlWord[`CRC_B_RSTN];
    endproperty
    a_rst_bit_one: assert property (p_rst_bit_one) else $error("soft reset bit stuck low"); // see RL14

    // Writing the run bit cannot start a halted core
    property p_run_ro;
        wrHit && avs_writedata[`CRC_B_RUN] && !coreIf.running && !stateFf.enable |=> !ctlWord[`CRC_B_RUN];
    endproperty
    a_run_ro: assert property (p_run_ro) else $error("run bit took a write"); // see RL15

    // Main scenarios
    c_step: cover property (stateFf.enable && stateFf.step && coreInstrDone ##1 !coreFetchEnable);
    c_soft: cover property (coreSoftReset);
    c_wake: cover property (coreWakeForce && coreSleeping);
    c_read: cover property (avs_read && !avs_waitrequest && ctlHit);

endmodule : crc_run_control

// ### hw/crc_regs.svh
// Register offsets, field positions and reset values of the run control register
//
// Notes on behaviour
// RL1 - Control register at offset 0, resets to 1
// RL2 - Bits 31-16 hold start address, reset zero
// RL3 - Bit 15 low: halted, host may access
// RL4 - Bit 15 high: running, host locked out
// RL5 - Step bit clear: core runs freely
// RL6 - Step bit set: one instruction, enable cleared
// RL7 - Step bit alone never starts the core
// RL8 - Step and enable together act as two writes
// RL9 - Bit 3 gates cycle counters, resets zero
// RL10 - Bit 2 reads one while core sleeps
// RL11 - Writing zero to bit 2 wakes core
// RL12 - Bit 1 enables fetch; clear halts after instruction
// RL13 - Halt keeps state; re-enable resumes in place
// RL14 - Clearing bit 0 resets; back next cycle
// RL15 - Read-only bits ignore writes; reserved bits store (reserved bit 14 always reads zero and is never stored)
`ifndef CRC_REGS_SVH
`define CRC_REGS_SVH

`define CRC_ADDR_W    4
`define CRC_CTRL_OFS  4'h0
`define CRC_CTRL_RST  32'h0000_0001
`define CRC_B_RSTN    0
`define CRC_B_EN      1
`define CRC_B_SLEEP   2
`define CRC_B_CNT     3
`define CRC_B_STEP    8
`define CRC_B_RSV14   14
`define CRC_B_RUN     15
`define CRC_START_HI  31
`define CRC_START_LO  16
`define CRC_RSVA_HI   13
`define CRC_RSVA_LO   9
`define CRC_RSVB_HI   7
`define CRC_RSVB_LO   4

`endif

// ### hw/crc_pkg.sv
// Types shared by the run control block and its run-state tracker
package crc_pkg;

    // Run state of the core, one-hot
    typedef enum logic [2:0] {
        HALTED   = 3'b001,
        RUNNING  = 3'b010,
        DRAINING = 3'b100
    } crc_run_state_t;

    // Tracker state
    typedef struct packed {
        crc_run_state_t execution_indicator;
    } crc_trk_state_t;

    // Register block state
    typedef struct packed {
        logic [15:0] startAddr;
        logic [4:0]  rsvA;
        logic        step;
        logic [3:0]  rsvB;
        logic        cntEn;
        logic        enable;
        logic        rstN;
        logic        ack;
        logic [31:0] readData;
        logic        softRst;
        logic        wake;
    } crc_ctl_state_t;

endpackage : crc_pkg

// ### hw/crc_core_if.sv
// Signals between the register block and the run-state tracker
`timescale 1ns/10ps
interface crc_core_if;
    logic fetchEn;    // Fetch permitted
    logic instrDone;  // Core retired an instruction
    logic multiBusy;  // Multi-cycle instruction past its first cycle
    logic running;    // Core executing

    modport ctl (output fetchEn, instrDone, multiBusy, input running);
    modport trk (input fetchEn, instrDone, multiBusy, output running);
endinterface : crc_core_if

// ### hw/crc_run_tracker.sv
// Tracks whether the core is running, halted or finishing an instruction
`timescale 1ns/10ps
`include "crc_regs.svh"
module crc_run_tracker (
    input wire logic core_clk,
    input wire logic sys_rst,
    crc_core_if.trk  coreIf
);

    crc_pkg::crc_trk_state_t stateFf;   // Registered state
    crc_pkg::crc_trk_state_t nxtState;  // Next state

    // Next run state
    always_comb begin
        nxtState = stateFf;
        case (stateFf.execution_indicator)
            crc_pkg::HALTED: begin
                // State was kept, so fetch resumes in place
                if (coreIf.fetchEn) begin
                    nxtState.execution_indicator = crc_pkg::RUNNING; // see RL13
                end
            end
            crc_pkg::RUNNING: begin
                // Halt at once unless an instruction is mid-way
                if (!coreIf.fetchEn) begin
                    if (coreIf.multiBusy && !coreIf.instrDone) begin
                        nxtState.execution_indicator = crc_pkg::DRAINING; // see RL12
                    end else begin
                        nxtState.execution_indicator = crc_pkg::HALTED; // see RL12
                    end
                end
            end
            crc_pkg::DRAINING: begin
                // Instruction completes before the pause
                if (coreIf.instrDone) begin
                    nxtState.execution_indicator = coreIf.fetchEn ? crc_pkg::RUNNING : crc_pkg::HALTED;
                end
            end
            default: begin
                nxtState.execution_indicator = crc_pkg::HALTED;
            end
        endcase
    end

    // State register
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            stateFf <= '{execution_indicator: crc_pkg::HALTED};
        end else begin
            stateFf <= nxtState;
        end
    end

    assign coreIf.running = (stateFf.execution_indicator != crc_pkg::HALTED);

    // Checks
    property p_drain_hold;
        @(posedge core_clk) disable iff (sys_rst)
        (stateFf.execution_indicator == crc_pkg::RUNNING) && !coreIf.fetchEn && coreIf.multiBusy && !coreIf.instrDone
        |=> coreIf.running [*1] ##0 (stateFf.execution_indicator == crc_pkg::DRAINING);
    endproperty
    a_drain_hold: assert property (p_drain_hold) else $error("halt did not wait for instruction"); // see RL12

    property p_halt_now;
        @(posedge core_clk) disable iff (sys_rst)
        (stateFf.execution_indicator == crc_pkg::RUNNING) && !coreIf.fetchEn && !coreIf.multiBusy |=> !coreIf.running;
    endproperty
    a_halt_now: assert property (p_halt_now) else $error("core did not halt at once"); // see RL12

    property p_resume;
        @(posedge core_clk) disable iff (sys_rst)
        !coreIf.running && coreIf.fetchEn |=> coreIf.running;
    endproperty
    a_resume: assert property (p_resume) else $error("core did not resume"); // see RL13

    c_drain: cover property (@(posedge core_clk) stateFf.execution_indicator == crc_pkg::DRAINING ##1
        stateFf.execution_indicator == crc_pkg::HALTED);

endmodule : crc_run_tracker

// ### test/tb_top.sv
// Self-checking bench for the run control register on its Avalon-MM slave
`timescale 1ns/10ps
`include "crc_regs.svh"
module tb_top;
    logic                   core_clk;         // Bench clock
    logic                   sys_rst;          // Synchronous reset
    logic [`CRC_ADDR_W-1:0] avs_address;      // Bus address
    logic                   avs_read;         // Read request
    logic                   avs_write;        // Write request
    logic [31:0]            avs_writedata;    // Write data
    logic [3:0]             avs_byteenable;   // Byte lanes
    logic [31:0]            avs_readdata;     // Read data
    logic                   avs_waitrequest;  // Slave stall
    logic                   coreInstrDone;    // Retire pulse
    logic                   coreMultiBusy;    // Multi-cycle in progress
    logic                   coreSleeping;     // Core asleep
    logic                   coreFetchEnable;  // Fetch permitted
    logic                   coreStepMode;     // Single-step policy
    logic                   coreSoftReset;    // Core reset pulse
    logic [15:0]            coreStartAddress; // Start address
    logic                   cycleCountEnable; // Counter gate
    logic                   coreWakeForce;    // Wake pulse
    logic                   hostLockout;      // Host locked out
    logic                   executionIndicator; // Running
    int                     fails;            // Mismatch count
    int                     n_compared;       // Comparison count
    logic [31:0]            rd;               // Last read word

    crc_run_control crc_run_control_i (.core_clk(core_clk), .sys_rst(sys_rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .coreInstrDone(coreInstrDone), .coreMultiBusy(coreMultiBusy), .coreSleeping(coreSleeping),
        .coreFetchEnable(coreFetchEnable), .coreStepMode(coreStepMode), .coreSoftReset(coreSoftReset),
        .coreStartAddress(coreStartAddress), .cycleCountEnable(cycleCountEnable),
        .coreWakeForce(coreWakeForce), .hostLockout(hostLockout), .executionIndicator(executionIndicator));

    // Free-running 100 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // Verdict and end of run
    task automatic end_of_test;
        if (fails == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_of_test

    // Compare a register word
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_word

    // Compare a single port level
    task automatic chk_bit(input logic got, input logic exp);
        chk_word({31'h0, got}, {31'h0, exp});
    endtask : chk_bit

    // Wait a number of rising edges
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask : tick

    // One bus cycle, held until waitrequest is seen low, then released
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
        @(posedge core_clk);
        avs_address    <= a;
        avs_writedata  <= d;
        avs_byteenable <= be;
        avs_read       <= !wr;
        avs_write      <= wr;
        // Only the watchdog ends a wait that never finishes
        do begin
            @(posedge core_clk);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    // One-cycle retire pulse from the core
    task automatic retire;
        @(posedge core_clk);
        coreInstrDone <= 1'b1;
        @(posedge core_clk);
        coreInstrDone <= 1'b0;
    endtask : retire

    // Reset values, unmapped place, read-only bits and byte lanes
    task automatic t_regs;
        bus(0, 4'h0, 32'h0, 4'hf);
        chk_word(rd, 32'h0000_0001);
        chk_bit(cycleCountEnable | coreFetchEnable | executionIndicator, 1'b0);
        bus(1, 4'h0, 32'ha5c3_fefd, 4'hf);
        #1 chk_bit(coreWakeForce, 1'b0);
        chk_bit(cycleCountEnable, 1'b1);
        chk_word({16'h0, coreStartAddress}, 32'h0000_a5c3);
        bus(1, 4'h4, 32'h0, 4'hf);
        bus(0, 4'h4, 32'h0, 4'hf);
        chk_word(rd, 32'h0);
        coreSleeping <= 1'b1;
        bus(0, 4'h0, 32'h0, 4'hf);
        chk_word(rd, 32'ha5c3_3efd);
        coreSleeping <= 1'b0;
        bus(1, 4'h0, 32'h0, 4'h1);
        #1 chk_bit(coreSoftReset & coreWakeForce, 1'b1);
        @(posedge core_clk);
        #1 chk_bit(coreSoftReset | coreWakeForce, 1'b0);
        bus(0, 4'h0, 32'h0, 4'hf);
        chk_word(rd, 32'ha5c3_3e01);
    endtask : t_regs

    // Step bit alone must not start the core
    task automatic t_step_alone;
        bus(1, 4'h0, 32'h0000_3f05, 4'h3);
        tick(4);
        #1 chk_bit(executionIndicator | coreFetchEnable, 1'b0);
        chk_bit(coreStepMode, 1'b1);
        bus(1, 4'h0, 32'h0000_3e05, 4'h3);
    endtask : t_step_alone

    // Step and enable in one write: one instruction, then halt
    task automatic t_step;
        bus(1, 4'h0, 32'h0000_3f07, 4'h3);
        #1 chk_bit(coreFetchEnable & coreStepMode, 1'b1);
        @(posedge core_clk);
        #1 chk_bit(executionIndicator & hostLockout, 1'b1);
        bus(0, 4'h0, 32'h0, 4'hf);
        chk_word(rd, 32'ha5c3_bf03);
        retire;
        #1 chk_bit(coreFetchEnable, 1'b0);
        @(posedge core_clk);
        #1 chk_bit(executionIndicator | hostLockout, 1'b0);
        bus(1, 4'h0, 32'h0000_3e05, 4'h3);
    endtask : t_step

    // Free run, immediate halt, resume, halt after a multi-cycle instruction
    task automatic t_run;
        bus(1, 4'h0, 32'h0000_0007, 4'h1);
        retire;
        retire;
        retire;
        #1 chk_bit(coreFetchEnable & executionIndicator, 1'b1);
        bus(1, 4'h0, 32'h0000_0005, 4'h1);
        @(posedge core_clk);
        #1 chk_bit(executionIndicator, 1'b0);
        bus(1, 4'h0, 32'h0000_0007, 4'h1);
        @(posedge core_clk);
        #1 chk_bit(executionIndicator, 1'b1);
        chk_bit(coreSoftReset, 1'b0);
        chk_word({16'h0, coreStartAddress}, 32'h0000_a5c3);
        @(posedge core_clk);
        coreMultiBusy <= 1'b1;
        bus(1, 4'h0, 32'h0000_0005, 4'h1);
        tick(3);
        #1 chk_bit(executionIndicator, 1'b1);
        retire;
        coreMultiBusy <= 1'b0;
        tick(2);
        #1 chk_bit(executionIndicator, 1'b0);
    endtask : t_run

    // Second reset with the core halted restores the reset word
    task automatic t_rerst;
        @(posedge core_clk);
        sys_rst <= 1'b1;
        tick(2);
        sys_rst <= 1'b0;
        bus(0, 4'h0, 32'h0, 4'hf);
        chk_word(rd, 32'h0000_0001);
    endtask : t_rerst

    // Watchdog against a hang
    initial begin
        #200000;
        fails++;
        end_of_test();
    end

    // Main sequence
    initial begin
        fails = 0;
        n_compared = 0;
        sys_rst = 1'b1;
        avs_address = '0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = '0;
        avs_byteenable = '0;
        coreInstrDone = 1'b0;
        coreMultiBusy = 1'b0;
        coreSleeping = 1'b0;
        tick(10);
        sys_rst <= 1'b0;
        t_regs();
        t_step_alone();
        t_step();
        t_run();
        t_rerst();
        end_of_test();
    end
endmodule : tb_top
